/* logic/rsec_regs.svh */
// offsets, field positions, reset values and timing counts of the block
`ifndef RSEC_REGS_SVH
`define RSEC_REGS_SVH

`define RSEC_ADDR_W          5
`define RSEC_DATA_W          8
`define RSEC_OFS_MODE        5'h01
`define RSEC_OFS_USER        5'h0F
`define RSEC_MODE_RUN_BIT    0
`define RSEC_MODE_CASC_BIT   1
`define RSEC_USER_SENSE0_BIT 0
`define RSEC_USER_SENSE1_BIT 1
`define RSEC_USER_EN0_BIT    2
`define RSEC_USER_EN1_BIT    3
`define RSEC_MODE_RESET      8'h00
`define RSEC_USER_RESET      8'h00
`define RSEC_UNMAPPED_READ   8'h00
`define RSEC_CLK_PERIOD_PS   5000
`define RSEC_RST_MIN_NS      160
`define RSEC_RST_SETTLE_NS   960
`define RSEC_SENSE_MIN_NS    160

`endif

/* logic/rsec_pkg.sv */
// types shared by the reset, sense, enable and cascade block
`default_nettype none
package rsec_pkg;

   typedef enum logic [2:0] {
      RSEC_BUS_IDLE   = 3'b001,
      RSEC_BUS_ACCESS = 3'b010,
      RSEC_BUS_HOLD   = 3'b100
   } rsec_bus_state_t;

   typedef struct packed {
      logic       rd;
      logic [4:0] addr;
      logic [7:0] data;
      logic       par;
   } rsec_bus_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic       par;
   } rsec_bus_rsp_t;

endpackage

`default_nettype wire

/* logic/rsec_top.sv */
// reset, user sense/enable pins, cascade handshake and management access
`timescale 1ns/10ps
`default_nettype none
`include "rsec_regs.svh"

// Summary of operation
// - reset clears every internal register except the synchroniser ce_n bits, which load high, and the bus state, which loads RSEC_BUS_IDLE
// - reset forces stop mode, mode bit zero
// - sense input 0 held sets user bit 0
// - sense input 1 held sets user bit 1
// - sense bits stay set until bus clears
// - enable output 0 follows user bit 2
// - enable output 1 follows user bit 3
// - release ready when cascade mode and JK
// - cascade ready is open-drain, low until ready
// - internal logic runs on local byte clock
// - receive serial data on receive bit clock
// - transmit serial data on transmit bit clock
// - shift register block on transmit byte clock
module rsec_top
   import rsec_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ce_n,
   input  wire logic       rd_wr_n,
   input  wire logic [4:0] cb_addr,
   input  wire logic [7:0] cb_data_in,
   output logic      [7:0] cb_data_out,
   output logic            cb_data_oe_n,
   input  wire logic       cb_par_in,
   output logic            cb_par_out,
   output logic            cb_par_oe_n,
   input  wire logic       cb_par_en,
   output logic            ack_out,
   output logic            ack_oe_n,
   output logic            cb_par_error,
   input  wire logic       user_sense_in0,
   input  wire logic       user_sense_in1,
   output logic            user_enable_out0,
   output logic            user_enable_out1,
   output logic            sense_event,
   input  wire logic       jk_pair_rx,
   input  wire logic       cascade_start_in,
   output logic            cascade_start,
   output logic            cascade_ready_od,
   output logic            cascade_ready_oe_n,
   output logic            run_mode,
   output logic            cascade_mode_bit
);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts when 2 and 3 agree
   // bits: 0 ce_n, 1 sense0, 2 sense1, 3 cascade start
   logic [3:0] pin_raw;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic [3:0] pin_lvl;
   logic [3:0] next_sync1;
   logic [3:0] next_sync2;
   logic [3:0] next_sync3;
   logic [3:0] next_pin_lvl;
   logic [3:0] pin_high2;
   logic [3:0] next_pin_high2;

   assign pin_raw = {cascade_start_in, user_sense_in1, user_sense_in0, ce_n};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         always_comb begin
            next_sync1[gi]     = pin_raw[gi];
            next_sync2[gi]     = sync1[gi];
            next_sync3[gi]     = sync2[gi];
            next_pin_lvl[gi]   = (sync2[gi] == sync3[gi]) ? sync3[gi]
                                                           : pin_lvl[gi];
            // two agreeing high samples in a row
            next_pin_high2[gi] = sync2[gi] & sync3[gi];
         end
      end
   endgenerate

   // ce_n idles high so a floating bus never looks like a cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync1     <= 4'h1;
         sync2     <= 4'h1;
         sync3     <= 4'h1;
         pin_lvl   <= 4'h1;
         pin_high2 <= 4'h0;
      end else begin
         sync1     <= next_sync1;
         sync2     <= next_sync2;
         sync3     <= next_sync3;
         pin_lvl   <= next_pin_lvl;
         pin_high2 <= next_pin_high2;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // management access: ce_n low starts it, ack held until ce_n rises
   rsec_bus_state_t state;
   rsec_bus_state_t next_state;
   rsec_bus_req_t   req;
   rsec_bus_req_t   next_req;
   rsec_bus_rsp_t   rsp;
   rsec_bus_rsp_t   next_rsp;
   logic [7:0]      mode_reg;
   logic [7:0]      next_mode_reg;
   logic [7:0]      user_reg;
   logic [7:0]      next_user_reg;
   logic            par_err;
   logic            next_par_err;
   logic            casc_armed;
   logic            next_casc_armed;
   logic            start_prev;
   logic            next_start_prev;
   logic            wr_ok;
   logic            par_bad;
   logic [1:0]      sense_set;
   logic [7:0]      rd_value;

   // odd parity over data and parity bit
   assign par_bad = ~(^{req.data, req.par});
   assign wr_ok   = (state == RSEC_BUS_ACCESS) && !req.rd
                    && !(cb_par_en && par_bad);
   assign sense_set = {pin_high2[2], pin_high2[1]};

   always_comb begin
      unique case (req.addr)
         `RSEC_OFS_MODE: rd_value = mode_reg;
         `RSEC_OFS_USER: rd_value = user_reg;
         default:        rd_value = `RSEC_UNMAPPED_READ;
      endcase
   end

   always_comb begin
      next_state = state;
      next_req   = req;
      next_rsp   = rsp;
      unique case (state)
         RSEC_BUS_IDLE: begin
            // bus pins are held stable while ce_n is low
            if (!pin_lvl[0]) begin
               next_state = RSEC_BUS_ACCESS;
               next_req   = '{rd: rd_wr_n, addr: cb_addr,
                              data: cb_data_in, par: cb_par_in};
            end
         end
         RSEC_BUS_ACCESS: begin
            next_state    = RSEC_BUS_HOLD;
            next_rsp.data = rd_value;
            next_rsp.par  = ~(^rd_value);
         end
         RSEC_BUS_HOLD: begin
            if (pin_lvl[0]) begin
               next_state = RSEC_BUS_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      next_mode_reg = mode_reg;
      next_user_reg = user_reg;
      next_par_err  = (state == RSEC_BUS_ACCESS) && !req.rd
                      && cb_par_en && par_bad;
      if (wr_ok && req.addr == `RSEC_OFS_MODE) begin
         next_mode_reg = req.data;
      end
      if (wr_ok && req.addr == `RSEC_OFS_USER) begin
         // writing zero to a sense bit clears it, writing one keeps it
         next_user_reg = {req.data[7:2], user_reg[1:0] & req.data[1:0]};
      end
      // a new event beats a clear in the same cycle
      next_user_reg[`RSEC_USER_SENSE0_BIT] =
         next_user_reg[`RSEC_USER_SENSE0_BIT] | sense_set[0];
      next_user_reg[`RSEC_USER_SENSE1_BIT] =
         next_user_reg[`RSEC_USER_SENSE1_BIT] | sense_set[1];
   end

   ////////////////////////////////////////////////////////////////////
   // cascade: stay low until cascade mode and a JK pair arrive
   always_comb begin
      next_start_prev = pin_lvl[3];
      if (!mode_reg[`RSEC_MODE_CASC_BIT]) begin
         next_casc_armed = 1'b0;
      end else begin
         next_casc_armed = casc_armed | jk_pair_rx;
      end
   end

   // serial bit clocks and the shift block clock stay in the serdes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state      <= RSEC_BUS_IDLE;
         req        <= '0;
         rsp        <= '0;
         mode_reg   <= `RSEC_MODE_RESET;
         user_reg   <= `RSEC_USER_RESET;
         par_err    <= 1'b0;
         casc_armed <= 1'b0;
         start_prev <= 1'b0;
      end else begin
         state      <= next_state;
         req        <= next_req;
         rsp        <= next_rsp;
         mode_reg   <= next_mode_reg;
         user_reg   <= next_user_reg;
         par_err    <= next_par_err;
         casc_armed <= next_casc_armed;
         start_prev <= next_start_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   logic hold_rd;
   assign hold_rd = (state == RSEC_BUS_HOLD) && req.rd;

   assign cb_data_out        = rsp.data;
   assign cb_par_out         = rsp.par;
   assign cb_data_oe_n       = ~hold_rd;
   assign cb_par_oe_n        = ~hold_rd;
   assign ack_out            = 1'b0;
   assign ack_oe_n           = ~(state == RSEC_BUS_HOLD);
   assign cb_par_error       = par_err;
   assign user_enable_out0   = user_reg[`RSEC_USER_EN0_BIT];
   assign user_enable_out1   = user_reg[`RSEC_USER_EN1_BIT];
   assign sense_event        = user_reg[`RSEC_USER_SENSE0_BIT]
                               | user_reg[`RSEC_USER_SENSE1_BIT];
   // other devices' readiness is seen only through the wired line
   assign cascade_start      = pin_lvl[3] & ~start_prev;
   assign cascade_ready_od   = 1'b0;
   assign cascade_ready_oe_n = casc_armed;
   assign run_mode           = mode_reg[`RSEC_MODE_RUN_BIT];
   assign cascade_mode_bit   = mode_reg[`RSEC_MODE_CASC_BIT];

endmodule

`default_nettype wire

/* test/rsec_top_asserts.sv */
// bound property checks for the reset, sense, enable and cascade block
`timescale 1ns/10ps
`default_nettype none
module rsec_top_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ack_oe_n,
   input wire logic cb_data_oe_n,
   input wire logic user_sense_in0,
   input wire logic user_sense_in1,
   input wire logic user_enable_out0,
   input wire logic user_enable_out1,
   input wire logic sense_event,
   input wire logic jk_pair_rx,
   input wire logic cascade_ready_od,
   input wire logic cascade_ready_oe_n,
   input wire logic run_mode,
   input wire logic cascade_mode_bit
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_reset_clears_all: assert property ($rose(reset_n) |-> ack_oe_n
      && cb_data_oe_n && !user_enable_out0 && !sense_event
      && !cascade_ready_oe_n) else $error("state not cleared by reset");
   chk_reset_stop_mode: assert property ($rose(reset_n) |->
      !run_mode && !cascade_mode_bit) else $error("reset left run mode");
   // two agreeing samples, then latch and output: pin high 4 edges back
   chk_sense_needs_pin: assert property ($rose(sense_event) |->
      $past(user_sense_in0, 4) || $past(user_sense_in1, 4))
      else $error("sense no pin");
   chk_sense_sticky: assert property ($fell(sense_event) |->
      !ack_oe_n) else $error("sense bit lost without bus access");
   chk_enable0_source: assert property ($changed(user_enable_out0) |->
      !ack_oe_n) else $error("enable 0 moved without write");
   chk_enable1_source: assert property ($changed(user_enable_out1) |->
      !ack_oe_n) else $error("enable 1 moved without write");
   chk_ready_release: assert property ($rose(cascade_ready_oe_n) |->
      cascade_mode_bit && $past(jk_pair_rx)) else $error("early release");
   chk_ready_open_drain: assert property (cascade_ready_od == 1'b0)
      else $error("ready line driven high");
   cover property ($rose(sense_event));
   cover property ($rose(cascade_ready_oe_n));
   cover property (!ack_oe_n && !cb_data_oe_n);
endmodule
`default_nettype wire

/* test/rsec_far_model.sv */
// far side: user sense sources and cascade start logic
`timescale 1ns/10ps
`default_nettype none
module rsec_far_model (
   input  wire logic       clk,
   input  wire logic [1:0] sense_hold,
   input  wire logic       cascade_ready_oe_n,
   output var  logic       user_sense_in0,
   output var  logic       user_sense_in1,
   output var  logic       cascade_start_in
);
   int dly;
   initial begin
      {user_sense_in1, user_sense_in0, cascade_start_in} = 3'h0;
      dly = 0;
   end
   // ready line has a pull-up: released reads high
   always @(negedge clk) begin
      {user_sense_in1, user_sense_in0} <= sense_hold;
      if (cascade_ready_oe_n !== 1'b1) begin
         cascade_start_in <= 1'b0;
         dly <= $urandom_range(3, 0);
      end else if (dly == 0) begin
         cascade_start_in <= 1'b1;
      end else begin
         dly <= dly - 1;
      end
   end
endmodule
`default_nettype wire

/* test/test_rsec_top.sv */
// self-checking bench for the reset, sense, enable and cascade block
`timescale 1ns/10ps
`default_nettype none
`include "rsec_regs.svh"
module test_rsec_top
   import rsec_pkg::*;
   ;
   logic       clk, reset_n, ce_n, rd_wr_n, cb_par_in, cb_par_en, ack_out;
   logic       cb_data_oe_n, cb_par_out, cb_par_oe_n, ack_oe_n, cb_par_error;
   logic       user_sense_in0, user_sense_in1, user_enable_out0;
   logic       user_enable_out1, sense_event, jk_pair_rx, cascade_start_in;
   logic       cascade_start, cascade_ready_od, cascade_ready_oe_n;
   logic       run_mode, cascade_mode_bit, prev_ack;
   logic [4:0] cb_addr;
   logic [7:0] cb_data_in, cb_data_out, v;
   logic [1:0] sense_hold;
   logic [8:0] exp_q[$];
   int         errors, tests_run, n;
   rsec_top dut (.clk, .reset_n, .ce_n, .rd_wr_n, .cb_addr, .cb_data_in,
      .cb_data_out, .cb_data_oe_n, .cb_par_in, .cb_par_out, .cb_par_oe_n,
      .cb_par_en, .ack_out, .ack_oe_n, .cb_par_error, .user_sense_in0,
      .user_sense_in1, .user_enable_out0, .user_enable_out1, .sense_event,
      .jk_pair_rx, .cascade_start_in, .cascade_start, .cascade_ready_od,
      .cascade_ready_oe_n, .run_mode, .cascade_mode_bit);
   rsec_far_model far (.clk, .sense_hold, .cascade_ready_oe_n,
      .user_sense_in0, .user_sense_in1, .cascade_start_in);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [8:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ack(input logic lvl);
      n = 0;
      while (ack_oe_n !== lvl && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (n == 40) errors++;
   endtask
   // pins held from chip enable until acknowledge is seen low
   task automatic bus(input logic rd, bad, input logic [4:0] a,
                      input logic [7:0] d);
      @(negedge clk);
      {rd_wr_n, cb_addr, cb_data_in, ce_n} = {rd, a, d, 1'b0};
      cb_par_in = ~^d ^ bad;
      wait_ack(1'b0);
      // bad parity with checking on: write refused, error pulse with ack
      check("bus outputs", {cb_par_oe_n, cb_data_oe_n, cb_par_error, ack_out},
            {~rd, ~rd, !rd && bad && cb_par_en, 1'b0});
      ce_n = 1'b1;
      wait_ack(1'b1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back({~^e, e});
      bus(1'b1, 1'b0, a, 8'h00);
   endtask
   task automatic jk;
      @(negedge clk);
      jk_pair_rx = 1'b1;
      @(negedge clk);
      jk_pair_rx = 1'b0;
      @(negedge clk);
   endtask
   task automatic summarize;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(negedge clk) begin
      prev_ack <= ack_oe_n;
      if (prev_ack === 1'b1 && ack_oe_n === 1'b0 && rd_wr_n === 1'b1
          && exp_q.size() > 0)
         check("read data", {cb_par_out, cb_data_out}, exp_q.pop_front());
   end
   initial begin
      #(4000 * 5);
      errors++;
      summarize();
   end
   initial begin
      {reset_n, ce_n, rd_wr_n, cb_par_in, cb_par_en, jk_pair_rx} = 6'b010000;
      {cb_addr, cb_data_in, sense_hold, prev_ack} = 16'h0001;
      errors = 0;
      tests_run = 0;
      v = $urandom(15);
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      rd(`RSEC_OFS_USER, `RSEC_USER_RESET);
      rd(`RSEC_OFS_MODE, `RSEC_MODE_RESET);
      rd(5'h1E, `RSEC_UNMAPPED_READ);
      $display("reset values done");
      v = {v[7:2], 2'b00};
      cb_par_en = 1'b1;
      bus(1'b0, 1'b0, `RSEC_OFS_USER, v);
      check("enable 0", user_enable_out0, v[2]);
      check("enable 1", user_enable_out1, v[3]);
      bus(1'b0, 1'b1, `RSEC_OFS_USER, ~v);
      check("enable 1 kept", user_enable_out1, v[3]);
      rd(`RSEC_OFS_USER, v);
      $display("enables done");
      for (int i = 0; i < 2; i++) begin
         sense_hold[i] = 1'b1;
         repeat (8) @(negedge clk);
         sense_hold = 2'b00;
         repeat (4) @(negedge clk);
         check("sense event", sense_event, 1'b1);
         rd(`RSEC_OFS_USER, v | (8'h01 << i));
         bus(1'b0, 1'b0, `RSEC_OFS_USER, v);
         rd(`RSEC_OFS_USER, v);
      end
      $display("sense done");
      jk();
      check("ready held", cascade_ready_oe_n, 1'b0);
      bus(1'b0, 1'b0, `RSEC_OFS_MODE, 8'h02);
      check("ready low", cascade_ready_oe_n, 1'b0);
      jk();
      check("ready free", cascade_ready_oe_n, 1'b1);
      n = 0;
      while (cascade_start !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("start seen", n < 20, 1'b1);
      bus(1'b0, 1'b0, `RSEC_OFS_MODE, 8'h01);
      check("mode bits", {cascade_mode_bit, run_mode}, 2'b01);
      repeat (2) @(negedge clk);
      check("ready relowered", cascade_ready_oe_n, 1'b0);
      $display("cascade done");
      reset_n = 1'b0;
      repeat (32) @(negedge clk);
      reset_n = 1'b1;
      repeat (192) @(negedge clk);
      check("stop mode", run_mode, 1'b0);
      rd(`RSEC_OFS_USER, `RSEC_USER_RESET);
      check("reads left", 9'(exp_q.size()), 9'h000);
      $display("second reset done");
      summarize();
   end
endmodule
bind rsec_top rsec_top_asserts chk (.clk, .reset_n, .ack_oe_n, .cb_data_oe_n,
   .user_sense_in0, .user_sense_in1, .user_enable_out0, .user_enable_out1,
   .sense_event, .jk_pair_rx, .cascade_ready_od, .cascade_ready_oe_n,
   .run_mode, .cascade_mode_bit);
`default_nettype wire
